// *** core/wdrc_core.sv ***
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// [R1] After reset, fetch start address from 0xFFFE then 0xFFFF, high byte first.
// [R2] Reset forces the stack pointer to 0x00FF.
// [R3] Reset sets the global interrupt mask bit.
// [R4] During reset peripherals are off, pins are inputs, pullups off.
// [R5] External reset pin acts only when its enable bit is set.
// [R6] Status keeps one flag per source; debug force reset has none.
// [R7] Enabled watchdog reaching its overflow count without service resets.
// [R8] Watchdog enable reads set after every reset.
// [R9] Clearing watchdog enable stops any watchdog reset.
// [R10] Writing the status address clears the counter, status unchanged.
// [R11] Clock select: 0 picks the 1 kHz tick, 1 the bus clock.
// [R12] On 1 kHz, timeout select gives 32 or 256 counts.
// [R13] On bus clock, timeout select gives 2^13 or 2^18 counts.
// [R14] Out of reset: 1 kHz source, 256-count timeout.
// [R15] Options registers take only their first write after reset.
// [R16] First write to each options register clears the counter.
// [R17] Software services the watchdog from main flow, not handlers.
// [R18] Counter holds still in background debug mode.
// [R19] On bus clock the counter freezes in stop and resumes after.
// [R20] On 1 kHz the counter clears on stop entry, restarts from zero.
// [R21] Watchdog reset sets its flag alone, clearing other flags.
module wdrc_core
   import wdrc_pkg::*;
(
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Reset sources
   input wire logic reset_pin_n,
   input wire logic low_voltage_detect,
   input wire logic illegal_opcode_detect,
   input wire logic illegal_address_detect,
   input wire logic debug_force_reset,
   // Watchdog environment
   input wire logic tick_1khz,
   input wire logic debug_mode,
   input wire logic stop_mode,
   // Reset vector fetch
   input wire logic [7:0] vec_data,
   output logic vec_rd,
   output logic [15:0] vec_addr,
   // CPU start-up and system reset state
   output logic sys_reset_n,
   output logic cpu_start,
   output logic [15:0] pc_value,
   output logic [15:0] stack_pointer,
   output logic ccr_imask,
   output logic periph_disable,
   output logic io_default_input
);

   // ****************************************************
   // Declarations
   // ****************************************************
   logic [2:0] hold_cnt;
   logic [2:0] next_hold;
   logic [5:0] reset_status;
   logic [5:0] next_status;
   logic watchdog_enable;
   logic watchdog_timeout_select;
   logic reset_pin_enable;
   logic watchdog_clock_select;
   logic opt1_locked;
   logic opt2_locked;
   logic [17:0] wd_cnt;
   wdrc_boot_type boot_state;

   // Overflow decode for the compare; the overflow check repeats it inline
   function automatic logic [17:0] wd_last(input logic clk_sel,
                                           input logic tsel);
      if (clk_sel)
      begin
         wd_last = tsel ? WD_LAST_BUS_LONG : WD_LAST_BUS_SHORT; // [R13]
      end
      else
      begin
         wd_last = tsel ? WD_LAST_1K_LONG : WD_LAST_1K_SHORT; // [R12]
      end
   endfunction

   // ****************************************************
   // APB decode
   // ****************************************************
   // Writes take effect only at the completing edge
   wire in_reset = ~sys_reset_n;
   wire setup_done = psel & penable & ~pready;
   wire wr_fire = psel & penable & pready & pwrite & sys_reset_n;
   wire sel_stat = paddr == RSTAT_ADDR;
   wire sel_opt1 = paddr == SYSTEM_OPTIONS_1_ADDR;
   wire sel_opt2 = paddr == SYSTEM_OPTIONS_2_ADDR;
   wire addr_ok = sel_stat | sel_opt1 | sel_opt2;
   wire wr_opt1 = wr_fire & sel_opt1 & ~opt1_locked; // [R15]
   wire wr_opt2 = wr_fire & sel_opt2 & ~opt2_locked; // [R15]
   wire [31:0] rd_value =
      sel_stat ? {26'h0, reset_status} :
      sel_opt1 ? {29'h0, reset_pin_enable, watchdog_timeout_select,
                  watchdog_enable} :
      sel_opt2 ? {31'h0, watchdog_clock_select} : 32'h0;

   // One wait state; unmapped addresses answer with an error
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= setup_done;
         pslverr <= setup_done & ~addr_ok;
         prdata <= (setup_done & ~pwrite) ? rd_value : 32'h0;
      end
   end

   // ****************************************************
   // Watchdog counter
   // ****************************************************
   // Service write and first option writes restart the count
   wire wd_service = (wr_fire & sel_stat) | wr_opt1 | wr_opt2; // [R10] [R16]
   // Clock choice; debug and stop both stall the count
   wire wd_tick = watchdog_clock_select | tick_1khz; // [R11]
   wire wd_inc = watchdog_enable & wd_tick & ~debug_mode // [R9] [R18]
                 & ~stop_mode; // [R19]
   // Slow source is held at zero across stop, so it restarts from zero
   wire wd_clear = in_reset | wd_service
                   | (stop_mode & ~watchdog_clock_select); // [R20]
   wire [17:0] wd_limit = wd_last(watchdog_clock_select,
                                  watchdog_timeout_select);
   wire wdog_to = wd_inc & ~wd_clear & (wd_cnt == wd_limit); // [R7]

   // Count register; clearing wins over counting
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wd_cnt <= 18'h0;
      end
      else if (wd_clear)
      begin
         wd_cnt <= 18'h0; // [R10]
      end
      else if (wd_inc)
      begin
         wd_cnt <= wd_cnt + 18'h1;
      end
   end

   // ****************************************************
   // Reset sources and status
   // ****************************************************
   // External pin only counts when enabled
   wire pin_rst = ~reset_pin_n & reset_pin_enable; // [R5]
   wire [5:0] src_flags = {illegal_address_detect, illegal_opcode_detect,
                           wdog_to, low_voltage_detect, 1'b0, pin_rst};
   // Debug force reset stretches reset but raises no flag
   wire any_req = (|src_flags) | debug_force_reset; // [R6]

   // Watchdog reset reports itself alone
   always_comb
   begin
      next_status = reset_status;
      if (wdog_to)
      begin
         next_status = STAT_WDOG_ONLY; // [R21]
      end
      else if (any_req)
      begin
         next_status = src_flags; // [R6]
      end
      next_hold = hold_cnt;
      if (any_req)
      begin
         next_hold = RST_HOLD_CYCLES;
      end
      else if (hold_cnt != 3'h0)
      begin
         next_hold = hold_cnt - 3'h1;
      end
   end

   // Status writes are ignored; only reset causes change it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reset_status <= STAT_POR_VALUE; // [R6]
         hold_cnt <= RST_HOLD_CYCLES;
         sys_reset_n <= 1'b0;
      end
      else
      begin
         reset_status <= next_status; // [R10]
         hold_cnt <= next_hold;
         sys_reset_n <= next_hold == 3'h0;
      end
   end

   // ****************************************************
   // System options, write once
   // ****************************************************
   // Locks keep a runaway program from turning the watchdog off
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         watchdog_enable <= RST_WD_EN;
         watchdog_timeout_select <= RST_WD_TSEL;
         reset_pin_enable <= RST_PIN_EN;
         watchdog_clock_select <= RST_WD_CLKSEL;
         opt1_locked <= 1'b0;
         opt2_locked <= 1'b0;
      end
      else if (in_reset)
      begin
         watchdog_enable <= RST_WD_EN; // [R8]
         watchdog_timeout_select <= RST_WD_TSEL; // [R14]
         reset_pin_enable <= RST_PIN_EN;
         watchdog_clock_select <= RST_WD_CLKSEL; // [R14]
         opt1_locked <= 1'b0;
         opt2_locked <= 1'b0;
      end
      else
      begin
         if (wr_opt1)
         begin
            watchdog_enable <= pwdata[OPT1_WD_EN];
            watchdog_timeout_select <= pwdata[OPT1_WD_TSEL];
            reset_pin_enable <= pwdata[OPT1_PIN_EN];
            opt1_locked <= 1'b1; // [R15]
         end
         if (wr_opt2)
         begin
            watchdog_clock_select <= pwdata[OPT2_WD_CLKSEL];
            opt2_locked <= 1'b1; // [R15]
         end
      end
   end

   // ****************************************************
   // Reset vector fetch and CPU start-up state
   // ****************************************************
   // Memory answers vec_data in the same cycle as vec_addr
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         boot_state <= BOOT_HOLD;
         vec_rd <= 1'b0;
         vec_addr <= VEC_ADDR_HI;
         pc_value <= 16'h0;
         cpu_start <= 1'b0;
         stack_pointer <= SP_INIT;
         ccr_imask <= 1'b1;
         periph_disable <= 1'b1;
         io_default_input <= 1'b1;
      end
      else if (in_reset)
      begin
         boot_state <= BOOT_HOLD;
         vec_rd <= 1'b0;
         cpu_start <= 1'b0;
         stack_pointer <= SP_INIT; // [R2]
         ccr_imask <= 1'b1; // [R3]
         periph_disable <= 1'b1; // [R4]
         io_default_input <= 1'b1; // [R4]
      end
      else
      begin
         case (boot_state)
            BOOT_HOLD:
            begin
               vec_rd <= 1'b1;
               vec_addr <= VEC_ADDR_HI; // [R1]
               boot_state <= BOOT_HI;
            end
            BOOT_HI:
            begin
               pc_value[15:8] <= vec_data; // [R1]
               vec_addr <= VEC_ADDR_LO;
               boot_state <= BOOT_LO;
            end
            BOOT_LO:
            begin
               pc_value[7:0] <= vec_data; // [R1]
               vec_rd <= 1'b0;
               cpu_start <= 1'b1;
               ccr_imask <= 1'b0; // [R3]
               periph_disable <= 1'b0;
               io_default_input <= 1'b0;
               boot_state <= BOOT_RUN;
            end
            BOOT_RUN:
            begin
               cpu_start <= 1'b0;
            end
            default:
            begin
               boot_state <= BOOT_HOLD;
            end
         endcase
      end
   end

   // ****************************************************
   // Assertions
   // ****************************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_fetch_hi;
      vec_rd && vec_addr == VEC_ADDR_HI;
   endsequence
   sequence s_fetch_lo;
      vec_rd && vec_addr == VEC_ADDR_LO;
   endsequence
   sequence s_started;
      cpu_start && !vec_rd && !ccr_imask;
   endsequence

   a_vector_fetch_order: assert property ( // [R1]
      $rose(sys_reset_n) |=> s_fetch_hi ##1 s_fetch_lo ##1 s_started)
      else $error("reset vector fetch out of order");
   a_reset_cpu_state: assert property ( // [R2] [R3] [R4]
      !sys_reset_n |=> stack_pointer == SP_INIT && ccr_imask
                       && periph_disable && io_default_input)
      else $error("cpu start-up state not forced in reset");
   a_pin_gated: assert property ( // [R5]
      sys_reset_n && !reset_pin_enable && !low_voltage_detect
      && !illegal_opcode_detect && !illegal_address_detect
      && !debug_force_reset && !wdog_to |=> sys_reset_n)
      else $error("reset taken without an enabled source");
   a_wdog_reset_flag: assert property ( // [R7] [R21]
      wdog_to |=> !sys_reset_n && reset_status == STAT_WDOG_ONLY)
      else $error("watchdog timeout did not reset alone");
   a_wdog_overflow_at: assert property ( // [R12] [R13]
      wdog_to |-> wd_cnt == (watchdog_clock_select
         ? (watchdog_timeout_select ? WD_LAST_BUS_LONG : WD_LAST_BUS_SHORT)
         : (watchdog_timeout_select ? WD_LAST_1K_LONG : WD_LAST_1K_SHORT)))
      else $error("overflow at wrong count");
   a_reset_defaults: assert property ( // [R8] [R14]
      $rose(sys_reset_n) |-> watchdog_enable && !watchdog_clock_select
                             && watchdog_timeout_select)
      else $error("watchdog defaults wrong after reset");
   a_wdog_disabled: assert property ( // [R9]
      !watchdog_enable |-> !wdog_to ##1 (wd_cnt == 18'h0 || $stable(wd_cnt)))
      else $error("disabled watchdog timed out");
   a_service_clears: assert property ( // [R10] [R16]
      wr_fire && (sel_stat || wr_opt1 || wr_opt2) |=> wd_cnt == 18'h0)
      else $error("service write did not clear counter");
   a_status_kept: assert property ( // [R10]
      wr_fire && sel_stat && !any_req |=> $stable(reset_status))
      else $error("status changed by write");
   a_opt1_once: assert property ( // [R15]
      wr_fire && sel_opt1 && opt1_locked |=>
      $stable(watchdog_enable) && $stable(watchdog_timeout_select))
      else $error("locked options register changed");
   a_debug_hold: assert property ( // [R18]
      debug_mode && !wd_clear |=> $stable(wd_cnt))
      else $error("counter moved in debug mode");
   a_stop_bus_hold: assert property ( // [R19]
      stop_mode && watchdog_clock_select && !wd_clear |=> $stable(wd_cnt))
      else $error("counter moved in stop on bus clock");
   a_stop_slow_zero: assert property ( // [R20]
      stop_mode && !watchdog_clock_select |=> wd_cnt == 18'h0)
      else $error("slow-clock counter not zero in stop");

endmodule // wdrc_core
`default_nettype wire

// *** inc/wdrc_pkg.sv ***
`default_nettype none
package wdrc_pkg;
   // ****************************************************
   // Register map (byte addresses on the APB)
   // ****************************************************
   localparam logic [11:0] RSTAT_ADDR = 12'h000;
   localparam logic [11:0] SYSTEM_OPTIONS_1_ADDR = 12'h004;
   localparam logic [11:0] SYSTEM_OPTIONS_2_ADDR = 12'h008;

   // Reset status flag positions
   localparam int ST_PIN = 0;
   localparam int ST_POR = 1;
   localparam int ST_LVD = 2;
   localparam int ST_WDOG = 3;
   localparam int ST_ILLEGAL_OPCODE_DETECT = 4;
   localparam int ST_ILLEGAL_ADDRESS_DETECT = 5;
   localparam logic [5:0] STAT_POR_VALUE = 6'h02;
   localparam logic [5:0] STAT_WDOG_ONLY = 6'h08;

   // System options 1 and 2 field positions
   localparam int OPT1_WD_EN = 0;
   localparam int OPT1_WD_TSEL = 1;
   localparam int OPT1_PIN_EN = 2;
   localparam int OPT2_WD_CLKSEL = 0;

   // Values after reset: watchdog on, 1 kHz source, long count
   localparam logic RST_WD_EN = 1'b1;
   localparam logic RST_WD_TSEL = 1'b1;
   localparam logic RST_WD_CLKSEL = 1'b0;
   localparam logic RST_PIN_EN = 1'b0;

   // ****************************************************
   // Watchdog overflow counts (last count value)
   // ****************************************************
   localparam logic [17:0] WD_LAST_1K_SHORT = 18'h0001f;
   localparam logic [17:0] WD_LAST_1K_LONG = 18'h000ff;
   localparam logic [17:0] WD_LAST_BUS_SHORT = 18'h01fff;
   localparam logic [17:0] WD_LAST_BUS_LONG = 18'h3ffff;

   // ****************************************************
   // CPU start-up values and reset stretch
   // ****************************************************
   localparam logic [15:0] VEC_ADDR_HI = 16'hfffe;
   localparam logic [15:0] VEC_ADDR_LO = 16'hffff;
   localparam logic [15:0] SP_INIT = 16'h00ff;
   localparam logic [2:0] RST_HOLD_CYCLES = 3'h4;

   typedef enum logic [1:0] {
      BOOT_HOLD,
      BOOT_HI,
      BOOT_LO,
      BOOT_RUN
   } wdrc_boot_type;
endpackage
`default_nettype wire

// *** tb/wdrc_core_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module wdrc_core_bench
   import wdrc_pkg::*;
;
   // ****************************************
   // Stimulus, clock and design
   // ****************************************
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic reset_pin_n = 1'b1;
   logic low_voltage_detect = 1'b0;
   logic illegal_opcode_detect = 1'b0;
   logic illegal_address_detect = 1'b0;
   logic debug_force_reset = 1'b0;
   logic tick_1khz = 1'b0;
   logic debug_mode = 1'b0;
   logic stop_mode = 1'b0;
   logic [7:0] vec_data;
   logic [31:0] prdata;
   logic pready, pslverr, vec_rd, sys_reset_n, cpu_start;
   logic ccr_imask, periph_disable, io_default_input;
   logic [15:0] vec_addr, pc_value, stack_pointer;
   int tcnt = 0;
   int err_total = 0;
   int check_count = 0;

   // Bus clock, 100 ns period
   initial
   begin
      forever #50 pclk = ~pclk;
   end

   // Tick every 20 cycles: shortens the slow source, counts stay exact
   always @(posedge pclk)
   begin
      tcnt <= (tcnt == 19) ? 0 : tcnt + 1;
      tick_1khz <= (tcnt == 19);
   end

   // Vector memory: start address 0x1234
   assign vec_data = vec_addr[0] ? 8'h34 : 8'h12;

   wdrc_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .reset_pin_n(reset_pin_n),
      .low_voltage_detect(low_voltage_detect),
      .illegal_opcode_detect(illegal_opcode_detect),
      .illegal_address_detect(illegal_address_detect),
      .debug_force_reset(debug_force_reset), .tick_1khz(tick_1khz),
      .debug_mode(debug_mode), .stop_mode(stop_mode),
      .vec_data(vec_data), .vec_rd(vec_rd), .vec_addr(vec_addr),
      .sys_reset_n(sys_reset_n), .cpu_start(cpu_start),
      .pc_value(pc_value), .stack_pointer(stack_pointer),
      .ccr_imask(ccr_imask), .periph_disable(periph_disable),
      .io_default_input(io_default_input));

   // ****************************************
   // Shared tasks
   // ****************************************
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // APB transfer; answer taken at the edge that sees pready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      chk({31'h0, pready}, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   task rd(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, x);
   endtask

   // No system reset for n cycles
   task quiet(input int n);
      logic ok;
      ok = 1'b1;
      repeat (n)
      begin
         @(negedge pclk);
         if (sys_reset_n !== 1'b1)
            ok = 1'b0;
      end
      chk({31'h0, ok}, 32'h1);
   endtask

   // Early exit so the boot that follows is not missed
   task expect_rst(input int n);
      logic ok;
      ok = 1'b0;
      for (int i = 0; i < n && ok == 1'b0; i++)
      begin
         @(negedge pclk);
         if (sys_reset_n === 1'b0)
            ok = 1'b1;
      end
      chk({31'h0, ok}, 32'h1);
   endtask

   task wait_boot();
      logic ok;
      ok = 1'b0;
      for (int i = 0; i < 200 && ok == 1'b0; i++)
      begin
         @(negedge pclk);
         if (cpu_start === 1'b1)
            ok = 1'b1;
      end
      chk({31'h0, ok}, 32'h1);
   endtask

   task drive(input logic v, input logic [2:0] k);
      @(posedge pclk);
      case (k)
         3'h0: reset_pin_n <= !v;
         3'h1: low_voltage_detect <= v;
         3'h2: illegal_opcode_detect <= v;
         3'h3: illegal_address_detect <= v;
         3'h4: debug_force_reset <= v;
         3'h5: debug_mode <= v;
         default: stop_mode <= v;
      endcase
   endtask

   task src(input logic [2:0] k, input logic [31:0] x);
      drive(1'b1, k);
      drive(1'b0, k);
      expect_rst(5);
      wait_boot();
      rd(RSTAT_ADDR, x);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task t_boot();
      chk({16'h0, stack_pointer}, {16'h0, SP_INIT});
      chk({31'h0, ccr_imask}, 32'h1);
      chk({30'h0, periph_disable, io_default_input}, 32'h3);
      presetn <= 1'b1;
      wait_boot();
      chk({16'h0, pc_value}, 32'h1234);
      chk({15'h0, vec_rd, vec_addr}, {16'h0, VEC_ADDR_LO});
      chk({31'h0, ccr_imask}, 32'h0);
      chk({30'h0, periph_disable, io_default_input}, 32'h0);
      rd(RSTAT_ADDR, {26'h0, STAT_POR_VALUE});
      rd(SYSTEM_OPTIONS_1_ADDR, 32'h3);
      rd(SYSTEM_OPTIONS_2_ADDR, 32'h0);
      $display("boot done");
   endtask

   task t_default();
      logic [31:0] q;
      logic e;
      quiet(5000);
      expect_rst(200);
      wait_boot();
      rd(RSTAT_ADDR, {26'h0, STAT_WDOG_ONLY});
      rd(SYSTEM_OPTIONS_1_ADDR, 32'h3);
      apb(1'b0, 12'h00c, 32'h0, q, e);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      wr(RSTAT_ADDR, 32'hff);
      rd(RSTAT_ADDR, {26'h0, STAT_WDOG_ONLY});
      $display("default timeout done");
   endtask

   task t_lock();
      wr(SYSTEM_OPTIONS_1_ADDR, 32'h0);
      wr(SYSTEM_OPTIONS_1_ADDR, 32'h3);
      rd(SYSTEM_OPTIONS_1_ADDR, 32'h0);
      wr(SYSTEM_OPTIONS_2_ADDR, 32'h1);
      wr(SYSTEM_OPTIONS_2_ADDR, 32'h0);
      rd(SYSTEM_OPTIONS_2_ADDR, 32'h1);
      quiet(9000);
      $display("lock done");
   endtask

   task t_sources();
      drive(1'b1, 3'h0);
      drive(1'b0, 3'h0);
      quiet(10);
      src(3'h1, 32'h04);
      wr(SYSTEM_OPTIONS_1_ADDR, 32'h5);
      src(3'h0, 32'h01);
      src(3'h2, 32'h10);
      src(3'h3, 32'h20);
      src(3'h4, 32'h00);
      $display("sources done");
   endtask

   // Slow source short count; pause by debug (5) or stop (6)
   task t_slow(input logic [2:0] k, input int rest);
      wr(SYSTEM_OPTIONS_1_ADDR, 32'h1);
      quiet(300);
      drive(1'b1, k);
      quiet(1000);
      drive(1'b0, k);
      quiet(rest);
      expect_rst(140);
      wait_boot();
      $display("slow source pause done");
   endtask

   task t_bus();
      wr(SYSTEM_OPTIONS_2_ADDR, 32'h1);
      wr(SYSTEM_OPTIONS_1_ADDR, 32'h1);
      quiet(8000);
      wr(RSTAT_ADDR, 32'h0);
      quiet(8150);
      expect_rst(100);
      wait_boot();
      rd(RSTAT_ADDR, {26'h0, STAT_WDOG_ONLY});
      wr(SYSTEM_OPTIONS_2_ADDR, 32'h1);
      wr(SYSTEM_OPTIONS_1_ADDR, 32'h1);
      quiet(4000);
      drive(1'b1, 3'h6);
      quiet(6000);
      drive(1'b0, 3'h6);
      quiet(4000);
      expect_rst(300);
      wait_boot();
      $display("bus clock done");
   endtask

   task summarize();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Main sequence; reset held six cycles
   initial
   begin
      repeat (6) @(posedge pclk);
      t_boot();
      t_default();
      t_lock();
      t_sources();
      t_slow(3'h5, 280);
      t_slow(3'h6, 600);
      t_bus();
      summarize();
   end

   // Run needs about 48500 cycles
   initial
   begin
      repeat (80000) @(posedge pclk);
      err_total++;
      summarize();
   end
endmodule // wdrc_core_bench
`default_nettype wire
